/* File: rtl/tp_tap_regs.sv */
`timescale 1ns/1ps
`include "tp_map.svh"
module tp_tap_regs
    import tp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // Register access from the serial front end
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    output logic            reg_rvalid_out,
    // Pulse qualifier results per axis {z,y,x}, step, then latency and window timing
    input  wire logic [2:0] tap_in,
    input  wire logic [2:0] start_in,
    input  wire logic [2:0] pol_in,
    input  wire logic       step_in,
    input  wire logic [7:0] latency_in,
    input  wire logic [7:0] window_in,
    // Status level
    output logic            tap_event_active_out
);
    logic [7:0] cfg_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic       cfg_wr;
    logic       stat_rd;
    logic       load;
    logic       latch_on;

    tp_evt_if evt ();

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: first tap, latency, second-tap window
    tp_tap_seq u_seq (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .tap_in      (tap_in),
        .start_in    (start_in),
        .pol_in      (pol_in),
        .step_in     (step_in),
        .latency_in  (latency_in),
        .window_in   (window_in),
        .abort_en_in (cfg_reg[`TP_CFG_ABORT]),
        .sgl_en_in   (tp_sgl_en(cfg_reg)),
        .dbl_en_in   (tp_dbl_en(cfg_reg)),
        .evt         (evt.src)
    );

    // Read answer one cycle after the request
    tp_read_port u_rd (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .rd_in      (reg_rd_in),
        .addr_in    (reg_addr_in),
        .cfg_in     (cfg_reg),
        .status_in  (status_reg),
        .rdata_out  (reg_rdata_out),
        .rvalid_out (reg_rvalid_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign cfg_wr   = reg_wr_in && (reg_addr_in == `TP_ADDR_CFG);
    assign stat_rd  = reg_rd_in && (reg_addr_in == `TP_ADDR_STAT);
    assign latch_on = cfg_reg[`TP_CFG_LATCH];

    // Latched flags refuse new events until read; unlatched ones follow.
    // A read in the same cycle frees the latch, so that event is not lost.
    assign load = evt.valid
                  && (!latch_on || !status_reg[`TP_ST_EA] || stat_rd);

    // Config register; status is read only, writes to it are dropped
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_reg <= `TP_CFG_RST;
        end else if (ce_in && cfg_wr) begin
            cfg_reg <= reg_wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status value for a newly taken event
    always_comb begin
        status_next                             = `TP_STAT_RST;
        status_next[`TP_ST_EA]                  = 1'b1;
        status_next[`TP_ST_AXZ:`TP_ST_AXX]      = evt.axes;
        status_next[`TP_ST_DBL]                 = evt.dbl;
        status_next[`TP_ST_POLZ:`TP_ST_POLX]    = evt.pol;
    end

    // Event load wins over a read clear in the same cycle
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_reg <= `TP_STAT_RST;
        end else if (ce_in) begin
            if (load) begin
                status_reg <= status_next;
            end else if (stat_rd) begin
                status_reg <= `TP_STAT_RST;
            end
        end
    end

    assign tap_event_active_out = status_reg[`TP_ST_EA];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_latch_hold;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && latch_on && status_reg[`TP_ST_EA] && !stat_rd)
        |=> $stable(status_reg);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched flags changed without a read");

    property p_read_clear;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && stat_rd && !evt.valid) |=> status_reg == `TP_STAT_RST;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status not cleared by read");

    property p_dbl_mask;
        @(posedge sys_clk_in) disable iff (rst_in)
        (evt.valid && evt.dbl) |-> (evt.axes & ~tp_dbl_en(cfg_reg)) == 3'h0;
    endproperty
    a_dbl_mask: assert property (p_dbl_mask)
        else $error("double tap flagged on disabled axis");

    property p_sgl_mask;
        @(posedge sys_clk_in) disable iff (rst_in)
        (evt.valid && !evt.dbl) |-> (evt.axes & ~tp_sgl_en(cfg_reg)) == 3'h0;
    endproperty
    a_sgl_mask: assert property (p_sgl_mask)
        else $error("single tap flagged on disabled axis");

    property p_ea_cause;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(status_reg[`TP_ST_EA]) |-> $past(evt.valid) && $past(ce_in);
    endproperty
    a_ea_cause: assert property (p_ea_cause)
        else $error("event active without an event");

    property p_axes;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && load) |=>
            status_reg[`TP_ST_AXZ:`TP_ST_AXX] == $past(evt.axes)
            && status_reg[`TP_ST_EA];
    endproperty
    a_axes: assert property (p_axes)
        else $error("axis flags do not match event");

    property p_dbl_bit;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && load) |=> status_reg[`TP_ST_DBL] == $past(evt.dbl);
    endproperty
    a_dbl_bit: assert property (p_dbl_bit)
        else $error("double bit wrong");

    property p_pol;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && load) |=>
            status_reg[`TP_ST_POLZ:`TP_ST_POLX] == $past(evt.pol);
    endproperty
    a_pol: assert property (p_pol)
        else $error("polarity bits wrong");

    property p_follow;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && !latch_on && evt.valid) |=>
            status_reg[`TP_ST_AXZ:`TP_ST_AXX] == $past(evt.axes);
    endproperty
    a_follow: assert property (p_follow)
        else $error("unlatched flags did not follow event");

    // Event meeting a read clear must survive it
    property p_set_wins;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && evt.valid && stat_rd) |=> status_reg[`TP_ST_EA];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost to a status read");

    // Event active only drops after a status read
    property p_ea_drop;
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(status_reg[`TP_ST_EA]) |-> $past(stat_rd) && $past(ce_in);
    endproperty
    a_ea_drop: assert property (p_ea_drop)
        else $error("event active cleared without a read");
endmodule

/* File: rtl/tp_map.svh */
`ifndef TP_MAP_SVH
`define TP_MAP_SVH
// Register addresses and reset values
`define TP_ADDR_CFG  8'h21
`define TP_ADDR_STAT 8'h22
`define TP_CFG_RST   8'h00
`define TP_STAT_RST  8'h00
`define TP_RD_NONE   8'h00
// Config field positions
`define TP_CFG_ABORT 7
`define TP_CFG_LATCH 6
`define TP_CFG_ZDBL  5
`define TP_CFG_ZSGL  4
`define TP_CFG_YDBL  3
`define TP_CFG_YSGL  2
`define TP_CFG_XDBL  1
`define TP_CFG_XSGL  0
// Status field positions
`define TP_ST_EA     7
`define TP_ST_AXZ    6
`define TP_ST_AXX    4
`define TP_ST_DBL    3
`define TP_ST_POLZ   2
`define TP_ST_POLX   0
// Step counter values
`define TP_CNT_ZERO  8'h00
`define TP_CNT_ONE   8'h01
`endif

/* File: rtl/tp_pkg.sv */
`include "tp_map.svh"
package tp_pkg;
    // Tap sequencer phases
    typedef enum logic [1:0] {
        tp_st_idle = 2'b00,
        tp_st_lat  = 2'b01,
        tp_st_win  = 2'b10
    } tp_state_t;

    // Single-tap enables as {z,y,x}
    function automatic logic [2:0] tp_sgl_en(input logic [7:0] cfg);
        return {cfg[`TP_CFG_ZSGL], cfg[`TP_CFG_YSGL], cfg[`TP_CFG_XSGL]};
    endfunction

    // Double-tap enables as {z,y,x}
    function automatic logic [2:0] tp_dbl_en(input logic [7:0] cfg);
        return {cfg[`TP_CFG_ZDBL], cfg[`TP_CFG_YDBL], cfg[`TP_CFG_XDBL]};
    endfunction
endpackage

/* File: rtl/tp_evt_if.sv */
`timescale 1ns/1ps
// Qualified tap event from sequencer to status logic
interface tp_evt_if;
    logic       valid;
    logic [2:0] axes;
    logic [2:0] pol;
    logic       dbl;
    modport src (output valid, output axes, output pol, output dbl);
    modport dst (input valid, input axes, input pol, input dbl);
endinterface

/* File: rtl/tp_tap_seq.sv */
`timescale 1ns/1ps
`include "tp_map.svh"
module tp_tap_seq
    import tp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // Pulse qualifier results per axis {z,y,x}
    input  wire logic [2:0] tap_in,
    input  wire logic [2:0] start_in,
    input  wire logic [2:0] pol_in,
    input  wire logic       step_in,
    // Timing and enables
    input  wire logic [7:0] latency_in,
    input  wire logic [7:0] window_in,
    input  wire logic       abort_en_in,
    input  wire logic [2:0] sgl_en_in,
    input  wire logic [2:0] dbl_en_in,
    // Event out
    tp_evt_if.src           evt
);
    tp_state_t  state_reg;
    logic [7:0] cnt_reg;
    logic       started_reg;
    logic       abort_hit;

    // Pulse both started and ended inside latency
    assign abort_hit = abort_en_in && (started_reg || (|start_in)) && (|tap_in);

    ////////////////////////////////////////////////////////////////////////
    // Phase and step counter
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= tp_st_idle;
            cnt_reg   <= `TP_CNT_ZERO;
        end else if (ce_in) begin
            case (state_reg)
                tp_st_idle: begin
                    if (|tap_in) begin
                        if (latency_in == `TP_CNT_ZERO) begin
                            state_reg <= tp_st_win;
                            cnt_reg   <= window_in;
                        end else begin
                            state_reg <= tp_st_lat;
                            cnt_reg   <= latency_in;
                        end
                    end
                end
                tp_st_lat: begin
                    // New starts are ignored here unless abort applies
                    if (abort_hit) begin
                        state_reg <= tp_st_idle;
                    end else if (step_in) begin
                        if (cnt_reg <= `TP_CNT_ONE) begin
                            state_reg <= tp_st_win;
                            cnt_reg   <= window_in;
                        end else begin
                            cnt_reg <= cnt_reg - `TP_CNT_ONE;
                        end
                    end
                end
                tp_st_win: begin
                    if (|tap_in) begin
                        state_reg <= tp_st_idle;
                    end else if (step_in) begin
                        if (cnt_reg == `TP_CNT_ZERO) begin
                            state_reg <= tp_st_idle;
                        end else begin
                            cnt_reg <= cnt_reg - `TP_CNT_ONE;
                        end
                    end
                end
                default: state_reg <= tp_st_idle;
            endcase
        end
    end

    // Start seen during latency, for the abort check
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            started_reg <= 1'b0;
        end else if (ce_in) begin
            started_reg <= (state_reg == tp_st_lat) && !abort_hit
                           && (started_reg || (|start_in));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event emission, masked by the per-axis enables
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            evt.valid <= 1'b0;
            evt.axes  <= 3'h0;
            evt.pol   <= 3'h0;
            evt.dbl   <= 1'b0;
        end else if (ce_in) begin
            evt.valid <= 1'b0;
            if (state_reg == tp_st_idle && (|tap_in)) begin
                evt.valid <= |(tap_in & sgl_en_in);
                evt.axes  <= tap_in & sgl_en_in;
                evt.pol   <= pol_in & tap_in & sgl_en_in;
                evt.dbl   <= 1'b0;
            end else if (state_reg == tp_st_win && (|tap_in)) begin
                evt.valid <= |(tap_in & dbl_en_in);
                evt.axes  <= tap_in & dbl_en_in;
                evt.pol   <= pol_in & tap_in & dbl_en_in;
                evt.dbl   <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_lat_quiet;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && state_reg == tp_st_lat) |=> !evt.valid;
    endproperty
    a_lat_quiet: assert property (p_lat_quiet)
        else $error("event raised during latency");

    property p_abort;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && state_reg == tp_st_lat && abort_en_in && (|start_in)
         && (|tap_in)) |=> state_reg == tp_st_idle;
    endproperty
    a_abort: assert property (p_abort)
        else $error("double tap not suspended");

    property p_no_abort;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && state_reg == tp_st_lat && !abort_en_in && !step_in)
        |=> state_reg == tp_st_lat;
    endproperty
    a_no_abort: assert property (p_no_abort)
        else $error("double tap aborted while abort is off");
endmodule

/* File: rtl/tp_read_port.sv */
`timescale 1ns/1ps
`include "tp_map.svh"
module tp_read_port (
    // Clock, reset, enable
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // Read request
    input  wire logic       rd_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] cfg_in,
    input  wire logic [7:0] status_in,
    // Read answer
    output logic      [7:0] rdata_out,
    output logic            rvalid_out
);
    // Registered mux; unmapped addresses read as zero
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out  <= `TP_RD_NONE;
            rvalid_out <= 1'b0;
        end else if (ce_in) begin
            rvalid_out <= rd_in;
            if (rd_in) begin
                case (addr_in)
                    `TP_ADDR_CFG:  rdata_out <= cfg_in;
                    `TP_ADDR_STAT: rdata_out <= status_in;
                    default:       rdata_out <= `TP_RD_NONE;
                endcase
            end
        end
    end
endmodule

/* File: verif/tp_host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host side of the register port: one strobe pulse per access
module tp_host_model (
    // Clock and read answer
    input  wire logic       sys_clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    // Request lines
    output logic      [7:0] addr_out,
    output logic            wr_out,
    output logic            rd_out,
    output logic      [7:0] wdata_out
);
    // Idle values at time zero
    initial begin
        addr_out  = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        wdata_out = 8'h00;
    end

    // Released lines are scrambled so no stale value can pass for a match
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge sys_clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask

    // Read with a bounded wait for the answer pulse
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge sys_clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rvalid_in === 1'b1) begin
                ok = 1'b1;
                d  = rdata_in;
            end else begin
                @(posedge sys_clk_in);
            end
        end
    endtask
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
    logic       sys_clk;
    logic       rst;
    logic       ce;
    logic [2:0] tap;
    logic [2:0] start;
    logic [2:0] pol;
    logic       step;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;
    logic       ea;
    int         fail_count;
    int         samples_checked;

    tp_tap_regs u_tp_tap_regs (
        .sys_clk_in(sys_clk), .rst_in(rst), .ce_in(ce),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .tap_in(tap), .start_in(start), .pol_in(pol), .step_in(step),
        .latency_in(8'h02), .window_in(8'h02), .tap_event_active_out(ea)
    );

    tp_host_model u_tp_host_model (
        .sys_clk_in(sys_clk), .rdata_in(rdata), .rvalid_in(rvalid),
        .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata)
    );

    // Free-running system clock, 100 MHz
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and shared helpers
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A missing answer ends the run rather than hanging
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit         ok;
        u_tp_host_model.reg_read(a, d, ok);
        if (!ok) begin
            fail_count++;
            $display("Error %0t: no read answer", $time);
            test_done();
        end
        check8(d, exp);
    endtask

    // One tap pulse; status settles one edge after it is taken
    task automatic tap_go(input logic [2:0] t, input logic [2:0] p);
        @(posedge sys_clk);
        tap <= t;
        pol <= p;
        @(posedge sys_clk);
        tap <= 3'h0;
        pol <= ~p;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic steps(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            step <= 1'b1;
            @(posedge sys_clk);
            step <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h22, 8'h00);
        u_tp_host_model.reg_write(8'h22, 8'hff);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h3a, 8'h00);
    endtask

    // Latched: a later event must not disturb the first one's flags
    task automatic t_latched();
        u_tp_host_model.reg_write(8'h21, 8'h41);
        rd_chk(8'h21, 8'h41);
        tap_go(3'b111, 3'b101);
        check8({7'h00, ea}, 8'h01);
        steps(8);
        tap_go(3'b001, 3'b000);
        steps(8);
        // Event and read meet: read sees old flags, the event survives
        @(posedge sys_clk);
        tap <= 3'b001;
        pol <= 3'b000;
        fork
            rd_chk(8'h22, 8'h91);
            begin
                @(posedge sys_clk);
                tap <= 3'h0;
            end
        join
        rd_chk(8'h22, 8'h90);
        rd_chk(8'h22, 8'h00);
        check8({7'h00, ea}, 8'h00);
        steps(8);
    endtask

    // Unlatched: second event overwrites without a read between
    task automatic t_unlatched();
        u_tp_host_model.reg_write(8'h21, 8'h11);
        tap_go(3'b001, 3'b000);
        steps(8);
        tap_go(3'b100, 3'b100);
        rd_chk(8'h22, 8'hc4);
        steps(8);
    endtask

    task automatic t_double();
        u_tp_host_model.reg_write(8'h21, 8'h61);
        tap_go(3'b001, 3'b000);
        rd_chk(8'h22, 8'h90);
        tap_go(3'b001, 3'b001);
        rd_chk(8'h22, 8'h00);
        steps(3);
        tap_go(3'b101, 3'b100);
        rd_chk(8'h22, 8'hcc);
        steps(8);
    endtask

    // Short pulse inside latency, then a tap in the window
    task automatic t_abort(input logic [7:0] cfg, input logic [7:0] exp);
        u_tp_host_model.reg_write(8'h21, cfg);
        tap_go(3'b100, 3'b000);
        rd_chk(8'h22, 8'hc0);
        @(posedge sys_clk);
        start <= 3'b100;
        tap   <= 3'b100;
        @(posedge sys_clk);
        start <= 3'b000;
        tap   <= 3'b000;
        steps(3);
        tap_go(3'b100, 3'b000);
        rd_chk(8'h22, exp);
        steps(8);
    endtask

    // Clock enable low: a tap must leave no trace
    task automatic t_freeze();
        @(posedge sys_clk);
        ce  <= 1'b0;
        tap <= 3'b100;
        @(posedge sys_clk);
        tap <= 3'h0;
        @(posedge sys_clk);
        ce  <= 1'b1;
        rd_chk(8'h22, 8'h00);
        check8({7'h00, ea}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fail_count      = 0;
        samples_checked = 0;
        rst   = 1'b1;
        ce    = 1'b1;
        tap   = 3'h0;
        start = 3'h0;
        pol   = 3'h0;
        step  = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_latched();
        t_unlatched();
        t_double();
        t_abort(8'hb0, 8'hc0);
        t_abort(8'h30, 8'hc8);
        t_freeze();
        test_done();
    end
endmodule
